// ### pkg/fbp_defines.vh
// fbp_defines.vh: offsets, field positions, reset values and region limits
// for the flash block protection configuration block.
// assumes: included by bare name from the design files.
`ifndef FBP_DEFINES_VH
`define FBP_DEFINES_VH

// ----------------------------------------------------------------------
// configuration byte addresses, used directly as AXI byte addresses
// ----------------------------------------------------------------------
`define FBP_ADDR_W            24
`define FBP_MAIN_CP_ADDR      24'h300008
`define FBP_BOOT_CP_ADDR      24'h300009
`define FBP_MAIN_WP_ADDR      24'h30000A
// own registers
`define FBP_BBS_ADDR          24'h300010
`define FBP_STAT_ADDR         24'h300014

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FBP_BLK0_BIT          0
`define FBP_BLK1_BIT          1
`define FBP_BOOT_BIT          6
`define FBP_STAT_REJ_BIT      0
`define FBP_STAT_VIO_BIT      1

// ----------------------------------------------------------------------
// reset / unprogrammed values
// ----------------------------------------------------------------------
`define FBP_GUARD_UNPROG      1'h1
`define FBP_BBS_RESET         1'h0

// ----------------------------------------------------------------------
// region limits (program word address space, 22 bits)
// ----------------------------------------------------------------------
`define FBP_PA_W              22
`define FBP_BOOT_END_SMALL    22'h0007FF
`define FBP_BOOT_END_LARGE    22'h000FFF
`define FBP_BLK0_END          22'h001FFF
`define FBP_BLK1_START        22'h002000
`define FBP_BLK1_END          22'h003FFF

// ----------------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------------
`define FBP_RESP_OKAY         2'h0
`define FBP_RESP_SLVERR       2'h2

`endif

// ### verif/fbp_mem_host.sv
// fbp_mem_host.sv: fetch and self-programming side facing the guards.
// assumes: tasks are called right after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module fbp_mem_host (
    input  wire logic        ref_clk,
    output var  logic        pgm_req,
    output var  logic [21:0] pgm_addr,
    output var  logic [21:0] rd_addr,
    input  wire logic        rd_blocked,
    input  wire logic        pgm_grant,
    input  wire logic        pgm_reject
);
    initial begin
        pgm_req = 1'b0;
        pgm_addr = 22'h0;
        rd_addr = 22'h0;
    end
    task automatic fetch(input logic [21:0] a, output logic blk);
        rd_addr <= a;
        @(posedge ref_clk);
        blk = rd_blocked;
        rd_addr <= ~a;
    endtask
    // idle address is inverted so a stale value never looks valid
    task automatic pgm_op(input logic [21:0] a, output logic g, r);
        pgm_req <= 1'b1;
        pgm_addr <= a;
        @(posedge ref_clk);
        pgm_req <= 1'b0;
        pgm_addr <= ~a;
        @(posedge ref_clk);
        g = pgm_grant;
        r = pgm_reject;
    endtask
endmodule // fbp_mem_host
`default_nettype wire

// ### verif/fbp_protect_chk.sv
// fbp_protect_chk.sv: port-level assertions on fbp_protect_cfg.
// assumes: one clock, sync active-low reset, attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module fbp_protect_chk (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [21:0] rd_addr,
    input wire logic        rd_blocked,
    input wire logic        pgm_req,
    input wire logic [21:0] pgm_addr,
    input wire logic        pgm_grant,
    input wire logic        pgm_reject,
    input wire logic        boot_read_guard,
    input wire logic        block0_read_guard,
    input wire logic        block1_read_guard,
    input wire logic        block1_write_guard
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("no write response");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("no read data");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    // first edge after reset sees the reset value in $past
    a_guard_clear_only: assert property (nrst && $past(nrst) |->
        !$rose(block1_read_guard) && !$rose(boot_read_guard)
        && !$rose(block1_write_guard)) else $error("guard set again");
    a_blk1_fetch: assert property (rd_addr[21:13] == 9'h001 |->
        rd_blocked == !block1_read_guard) else $error("block1 fetch");
    a_blk0_fetch: assert property (rd_addr[21:12] == 10'h001 |->
        rd_blocked == !block0_read_guard) else $error("block0 fetch");
    a_boot_fetch: assert property (rd_addr <= 22'h0007FF |->
        rd_blocked == !boot_read_guard) else $error("boot fetch");
    a_pgm_answer: assert property (pgm_req |=> pgm_grant != pgm_reject)
        else $error("program answer");
    a_pgm_blk1: assert property (pgm_req && pgm_addr[21:13] == 9'h001
        && !block1_write_guard |=> pgm_reject) else $error("block1 write");
    a_pgm_idle: assert property (!pgm_req |=> !pgm_grant && !pgm_reject)
        else $error("spurious answer");
endmodule // fbp_protect_chk
bind fbp_protect_cfg fbp_protect_chk u_chk (
    .ref_clk(ref_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .rd_addr(rd_addr), .rd_blocked(rd_blocked),
    .pgm_req(pgm_req), .pgm_addr(pgm_addr), .pgm_grant(pgm_grant),
    .pgm_reject(pgm_reject), .boot_read_guard(boot_read_guard),
    .block0_read_guard(block0_read_guard),
    .block1_read_guard(block1_read_guard),
    .block1_write_guard(block1_write_guard));
`default_nettype wire

// ### verif/tb_top.sv
// tb_top.sv: register and guard tests for fbp_protect_cfg.
// assumes: fbp_defines.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_defines.vh"
module tb_top;
    logic        ref_clk, nrst, awv, awrdy, wv, wrdy, bv, br, arv, arrdy;
    logic        rv, rr, rblk, preq, pg, prj, gb, g0r, g1r, g0w, g1w;
    logic [31:0] awa, wd, ara, rdat;
    logic [21:0] rda, pa;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp;
    int          err_total, total_checks, cycles;
    fbp_protect_cfg DUT (.ref_clk(ref_clk), .nrst(nrst),
        .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .rd_addr(rda),
        .rd_blocked(rblk), .pgm_req(preq), .pgm_addr(pa), .pgm_grant(pg),
        .pgm_reject(prj), .boot_read_guard(gb), .block0_read_guard(g0r),
        .block1_read_guard(g1r), .block0_write_guard(g0w),
        .block1_write_guard(g1w));
    fbp_mem_host u_host (.ref_clk(ref_clk), .pgm_req(preq), .pgm_addr(pa),
        .rd_addr(rda), .rd_blocked(rblk), .pgm_grant(pg),
        .pgm_reject(prj));
    task automatic chk(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wrx(input logic [31:0] a, d, input logic [3:0] s);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        ws <= s;
        do begin
            @(posedge ref_clk);
            if (awrdy) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        // late bready makes the response wait and hold for one cycle
        br <= 1'b1;
        @(posedge ref_clk);
        chk("bresp", {30'h0, bresp}, a[4:2] == 3'h1 ? 32'h2 : 32'h0);
        br <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdx(input logic [31:0] a, e);
        arv <= 1'b1;
        ara <= a;
        do begin
            @(posedge ref_clk);
            if (arrdy) arv <= 1'b0;
        end while (rv !== 1'b1);
        // late rready makes the read data wait and hold for one cycle
        rr <= 1'b1;
        @(posedge ref_clk);
        chk("rdata", rdat, e);
        chk("rresp", {30'h0, rresp}, a[4:2] == 3'h1 ? 32'h2 : 32'h0);
        rr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic fx(input logic [21:0] a, input logic e);
        logic b;
        u_host.fetch(a, b);
        chk("rd_blocked", {31'h0, b}, {31'h0, e});
    endtask
    task automatic px(input logic [21:0] a, input logic e);
        logic g, r;
        u_host.pgm_op(a, g, r);
        chk("grant_reject", {30'h0, g, r}, {30'h0, !e, e});
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            tally_and_finish;
        end
    end
    initial begin
        {nrst, awv, wv, br, arv, rr, err_total, total_checks, cycles} = 0;
        {awa, wd, ara, ws} = 0;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rdx(`FBP_MAIN_CP_ADDR, 32'h3);
        rdx(`FBP_BOOT_CP_ADDR, 32'h4000);
        rdx(`FBP_MAIN_WP_ADDR, 32'h30000);
        chk("guards", {gb, g0r, g1r, g0w, g1w}, 32'h1F);
        fx(22'h002000, 1'b0);
        px(22'h002000, 1'b0);
        rdx(32'h300004, 32'h0);
        wrx(32'h300004, 32'h0, 4'hF);
        wrx(`FBP_MAIN_CP_ADDR, 32'hFFFFFFFE, 4'h1);
        rdx(`FBP_MAIN_CP_ADDR, 32'h2);
        wrx(`FBP_MAIN_CP_ADDR, 32'hFFFFFFFF, 4'h1);
        rdx(`FBP_MAIN_CP_ADDR, 32'h2);
        fx(22'h0007FF, 1'b0);
        fx(22'h000800, 1'b1);
        fx(22'h001FFF, 1'b1);
        wrx(`FBP_BBS_ADDR, 32'h1, 4'h1);
        fx(22'h000FFF, 1'b0);
        fx(22'h001000, 1'b1);
        wrx(`FBP_MAIN_CP_ADDR, 32'hFFFFFFFD, 4'h1);
        fx(22'h002000, 1'b1);
        fx(22'h003FFF, 1'b1);
        fx(22'h004000, 1'b0);
        wrx(`FBP_BOOT_CP_ADDR, 32'h0, 4'h2);
        rdx(`FBP_BOOT_CP_ADDR, 32'h0);
        fx(22'h000000, 1'b1);
        wrx(`FBP_MAIN_WP_ADDR, 32'hFFFEFFFF, 4'h4);
        px(22'h001000, 1'b1);
        px(22'h000FFF, 1'b0);
        px(22'h002000, 1'b0);
        wrx(`FBP_MAIN_WP_ADDR, 32'h0, 4'h0);
        px(22'h002000, 1'b0);
        wrx(`FBP_MAIN_WP_ADDR, 32'h0, 4'h4);
        px(22'h003FFF, 1'b1);
        px(22'h004000, 1'b0);
        rdx(`FBP_STAT_ADDR, 32'h3);
        wrx(`FBP_STAT_ADDR, 32'h3, 4'h1);
        rdx(`FBP_STAT_ADDR, 32'h0);
        rdx(`FBP_MAIN_WP_ADDR, 32'h0);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rdx(`FBP_MAIN_CP_ADDR, 32'h3);
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire

// ### verilog/fbp_protect_cfg.v
// fbp_protect_cfg.v: protection configuration bytes behind an AXI4-Lite
// slave, plus the gates for code reads and self-programming.
// assumes: one clock, synchronous active-low reset, master keeps one
// write and one read outstanding at most.
//
// What this block does
// - Block 1 (002000-003FFFh) is code protected while its read guard is 0.
// - Block 0 (000800/001000-001FFFh) is code protected while its guard is 0.
// - The boot block (to 0007FFh or 000FFFh) is code protected on bit 6 = 0.
// - Block 1 is write protected while bit 1 of the write byte is 0.
// - Block 0 is write protected while bit 0 of the write byte is 0.
// - Every guard bit starts at 1 unprogrammed and can only be cleared.
// - Unused bits of the three protection bytes always read as 0.
// - The bytes sit at 300008h, 300009h and 30000Ah.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_defines.vh"

module fbp_protect_cfg (
    input  wire                 ref_clk,
    input  wire                 nrst,
    // axi4-lite write address
    input  wire                 s_axi_awvalid,
    output wire                 s_axi_awready,
    input  wire [31:0]          s_axi_awaddr,
    // axi4-lite write data
    input  wire                 s_axi_wvalid,
    output wire                 s_axi_wready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    // axi4-lite write response
    output wire                 s_axi_bvalid,
    input  wire                 s_axi_bready,
    output wire [1:0]           s_axi_bresp,
    // axi4-lite read address
    input  wire                 s_axi_arvalid,
    output wire                 s_axi_arready,
    input  wire [31:0]          s_axi_araddr,
    // axi4-lite read data
    output wire                 s_axi_rvalid,
    input  wire                 s_axi_rready,
    output wire [31:0]          s_axi_rdata,
    output wire [1:0]           s_axi_rresp,
    // code fetch / table read check
    input  wire [`FBP_PA_W-1:0] rd_addr,
    output wire                 rd_blocked,
    // self-programming request
    input  wire                 pgm_req,
    input  wire [`FBP_PA_W-1:0] pgm_addr,
    output wire                 pgm_grant,
    output wire                 pgm_reject,
    // guard levels for the rest of the device
    output wire                 boot_read_guard,
    output wire                 block0_read_guard,
    output wire                 block1_read_guard,
    output wire                 block0_write_guard,
    output wire                 block1_write_guard
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg        blk0_rg_ff;
    reg        blk1_rg_ff;
    reg        boot_rg_ff;
    reg        blk0_wg_ff;
    reg        blk1_wg_ff;
    reg        bbs_ff;
    reg        rej_ff;
    reg        vio_ff;
    reg        aw_hold_ff;
    reg [31:0] aw_addr_ff;
    reg        w_hold_ff;
    reg [31:0] w_data_ff;
    reg [3:0]  w_strb_ff;
    reg        bvalid_ff;
    reg [1:0]  bresp_ff;
    reg        rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0]  rresp_ff;
    reg        grant_ff;
    reg        reject_ff;

    // ------------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------------
    wire rd_locked;
    wire pgm_locked;

    fbp_region_decode u_rd_dec (
        .addr               (rd_addr),
        .large_boot         (bbs_ff),
        .boot_read_guard    (boot_rg_ff),
        .block0_read_guard  (blk0_rg_ff),
        .block1_read_guard  (blk1_rg_ff),
        .block0_write_guard (blk0_wg_ff),
        .block1_write_guard (blk1_wg_ff),
        .in_boot            (),
        .in_blk0            (),
        .in_blk1            (),
        .read_locked        (rd_locked),
        .write_locked       ()
    );

    fbp_region_decode u_pg_dec (
        .addr               (pgm_addr),
        .large_boot         (bbs_ff),
        .boot_read_guard    (boot_rg_ff),
        .block0_read_guard  (blk0_rg_ff),
        .block1_read_guard  (blk1_rg_ff),
        .block0_write_guard (blk0_wg_ff),
        .block1_write_guard (blk1_wg_ff),
        .in_boot            (),
        .in_blk0            (),
        .in_blk1            (),
        .read_locked        (),
        .write_locked       (pgm_locked)
    );

    assign rd_blocked = rd_locked;

    // ------------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_hold_ff || aw_take;
    wire w_have  = w_hold_ff || w_take;
    wire do_wr   = aw_have && w_have && !bvalid_ff;

    wire [31:0] wa = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
    wire [31:0] wd = w_hold_ff ? w_data_ff : s_axi_wdata;
    wire [3:0]  ws = w_hold_ff ? w_strb_ff : s_axi_wstrb;

    // stall new beats until the response is taken
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready  = !w_hold_ff && !bvalid_ff;

    wire [23:0] wa_lo = wa[23:0];
    wire        wa_hi0 = (wa[31:24] == 8'h00);
    wire hit_mcp = wa_hi0 && (wa_lo == `FBP_MAIN_CP_ADDR);
    wire hit_bcp = wa_hi0 && (wa_lo == `FBP_BOOT_CP_ADDR);
    wire hit_mwp = wa_hi0 && (wa_lo == `FBP_MAIN_WP_ADDR);
    wire hit_bbs = wa_hi0 && (wa_lo == `FBP_BBS_ADDR);
    wire hit_st  = wa_hi0 && (wa_lo == `FBP_STAT_ADDR);
    wire wr_ok   = hit_mcp || hit_bcp || hit_mwp || hit_bbs || hit_st;

    // byte lane of each byte address: low two address bits pick the lane
    wire [7:0] lane_b = wd[{wa[1:0], 3'h0} +: 8];
    wire       lane_en = ws[wa[1:0]];

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    wire [23:0] ra_lo = s_axi_araddr[23:0];
    wire        ra_hi0 = (s_axi_araddr[31:24] == 8'h00);
    wire        ar_take = s_axi_arvalid && s_axi_arready;
    reg  [31:0] nxt_rdata;
    reg  [1:0]  nxt_rresp;
    reg  [7:0]  rbyte;

    always @* begin
        rbyte     = 8'h00;
        nxt_rresp = `FBP_RESP_OKAY;
        if (!ra_hi0) begin
            nxt_rresp = `FBP_RESP_SLVERR;
        end else if (ra_lo == `FBP_MAIN_CP_ADDR) begin
            rbyte = {6'h00, blk1_rg_ff, blk0_rg_ff};
        end else if (ra_lo == `FBP_BOOT_CP_ADDR) begin
            rbyte = {1'h0, boot_rg_ff, 6'h00};
        end else if (ra_lo == `FBP_MAIN_WP_ADDR) begin
            rbyte = {6'h00, blk1_wg_ff, blk0_wg_ff};
        end else if (ra_lo == `FBP_BBS_ADDR) begin
            rbyte = {7'h00, bbs_ff};
        end else if (ra_lo == `FBP_STAT_ADDR) begin
            rbyte = {6'h00, vio_ff, rej_ff};
        end else begin
            nxt_rresp = `FBP_RESP_SLVERR;
        end
        nxt_rdata = 32'h0000_0000;
        nxt_rdata[{s_axi_araddr[1:0], 3'h0} +: 8] = rbyte;
    end

    assign s_axi_arready = !rvalid_ff;

    // ------------------------------------------------------------------
    // self-programming gate
    // ------------------------------------------------------------------
    wire pg_rej = pgm_req && pgm_locked;
    wire pg_ok  = pgm_req && !pgm_locked;

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    wire stat_wr = do_wr && hit_st && lane_en;
    wire rej_clr = stat_wr && lane_b[`FBP_STAT_REJ_BIT];
    wire vio_clr = stat_wr && lane_b[`FBP_STAT_VIO_BIT];
    wire nxt_rej;
    wire nxt_vio;

    // set wins over a clear in the same cycle, so no event is lost
    assign nxt_rej = pg_rej || (rej_ff && !rej_clr);
    // sticky: records any fetch that hit a read-guarded region
    assign nxt_vio = rd_locked || (vio_ff && !vio_clr);

    always @(posedge ref_clk) begin
        if (!nrst) begin
            rej_ff <= 1'h0;
            vio_ff <= 1'h0;
        end else begin
            rej_ff <= nxt_rej;
            vio_ff <= nxt_vio;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!nrst) begin
            // reset stands in for the erased, unprogrammed array
            blk0_rg_ff <= `FBP_GUARD_UNPROG;
            blk1_rg_ff <= `FBP_GUARD_UNPROG;
            boot_rg_ff <= `FBP_GUARD_UNPROG;
            blk0_wg_ff <= `FBP_GUARD_UNPROG;
            blk1_wg_ff <= `FBP_GUARD_UNPROG;
            bbs_ff     <= `FBP_BBS_RESET;
            aw_hold_ff <= 1'h0;
            aw_addr_ff <= 32'h0000_0000;
            w_hold_ff  <= 1'h0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'h0;
            bresp_ff   <= 2'h0;
            rvalid_ff  <= 1'h0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= 2'h0;
            grant_ff   <= 1'h0;
            reject_ff  <= 1'h0;
        end else begin
            grant_ff  <= pg_ok;
            reject_ff <= pg_rej;
            if (aw_take && !do_wr) begin
                aw_hold_ff <= 1'h1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take && !do_wr) begin
                w_hold_ff <= 1'h1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_ff <= 1'h0;
                w_hold_ff  <= 1'h0;
                bvalid_ff  <= 1'h1;
                bresp_ff   <= wr_ok ? `FBP_RESP_OKAY : `FBP_RESP_SLVERR;
                if (lane_en) begin
                    // anding keeps a cleared bit cleared
                    if (hit_mcp) begin
                        blk0_rg_ff <= blk0_rg_ff & lane_b[`FBP_BLK0_BIT];
                        blk1_rg_ff <= blk1_rg_ff & lane_b[`FBP_BLK1_BIT];
                    end
                    if (hit_bcp)
                        boot_rg_ff <= boot_rg_ff & lane_b[`FBP_BOOT_BIT];
                    if (hit_mwp) begin
                        blk0_wg_ff <= blk0_wg_ff & lane_b[`FBP_BLK0_BIT];
                        blk1_wg_ff <= blk1_wg_ff & lane_b[`FBP_BLK1_BIT];
                    end
                    if (hit_bbs) bbs_ff <= lane_b[0];
                end
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'h0;
            end
            if (ar_take) begin
                rvalid_ff <= 1'h1;
                rdata_ff  <= nxt_rdata;
                rresp_ff  <= nxt_rresp;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_bvalid       = bvalid_ff;
    assign s_axi_bresp        = bresp_ff;
    assign s_axi_rvalid       = rvalid_ff;
    assign s_axi_rdata        = rdata_ff;
    assign s_axi_rresp        = rresp_ff;
    assign pgm_grant          = grant_ff;
    assign pgm_reject         = reject_ff;
    assign boot_read_guard    = boot_rg_ff;
    assign block0_read_guard  = blk0_rg_ff;
    assign block1_read_guard  = blk1_rg_ff;
    assign block0_write_guard = blk0_wg_ff;
    assign block1_write_guard = blk1_wg_ff;

endmodule // fbp_protect_cfg
`default_nettype wire

// ### verilog/fbp_region_decode.v
// fbp_region_decode.v: maps a program address onto its protection region
// and reports whether that region is read or write guarded.
// assumes: guard bits are active low, 1 means unprotected.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_defines.vh"

module fbp_region_decode (
    input  wire [`FBP_PA_W-1:0] addr,
    input  wire                 large_boot,
    input  wire                 boot_read_guard,
    input  wire                 block0_read_guard,
    input  wire                 block1_read_guard,
    input  wire                 block0_write_guard,
    input  wire                 block1_write_guard,
    output wire                 in_boot,
    output wire                 in_blk0,
    output wire                 in_blk1,
    output wire                 read_locked,
    output wire                 write_locked
);

    // ------------------------------------------------------------------
    // range selection
    // ------------------------------------------------------------------
    wire [`FBP_PA_W-1:0] boot_end;

    assign boot_end = large_boot ? `FBP_BOOT_END_LARGE
                                 : `FBP_BOOT_END_SMALL;
    assign in_boot  = (addr <= boot_end);
    assign in_blk0  = (addr > boot_end) && (addr <= `FBP_BLK0_END);
    assign in_blk1  = (addr >= `FBP_BLK1_START)
                   && (addr <= `FBP_BLK1_END);

    // ------------------------------------------------------------------
    // guard lookup
    // ------------------------------------------------------------------
    assign read_locked  = (in_boot && !boot_read_guard)
                       || (in_blk0 && !block0_read_guard)
                       || (in_blk1 && !block1_read_guard);
    // boot block write guard lives in a byte outside this block
    assign write_locked = (in_blk0 && !block0_write_guard)
                       || (in_blk1 && !block1_write_guard);

endmodule // fbp_region_decode
`default_nettype wire
